// >>> inc/lvt_err_pkg.sv
// Constants for the local vector entry, error status and spurious block.
package lvt_err_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_ENTRIES = 7;
    localparam int NUM_EXT = 4;
    localparam logic [11:0] OFS_SPURIOUS = 12'h0f0;
    localparam logic [11:0] OFS_ERROR_FLAGS = 12'h280;
    localparam logic [11:0] OFS_THERMAL = 12'h330;
    localparam logic [11:0] OFS_PERF = 12'h340;
    localparam logic [11:0] OFS_ERROR_ENTRY = 12'h370;
    localparam logic [11:0] OFS_EXT_FEATURE = 12'h400;
    localparam logic [11:0] OFS_EXT_FIRST = 12'h500;
    localparam logic [11:0] OFS_EXT_LAST = 12'h530;
    localparam int IDX_THERMAL = 0;
    localparam int IDX_PERF = 1;
    localparam int IDX_ERROR = 2;
    localparam int IDX_EXT0 = 3;
    localparam logic THERMAL_PRESENT = 1'b1;
    localparam int POS_MASK = 16;
    localparam int POS_PENDING = 12;
    localparam int POS_KIND_LO = 8;
    localparam int POS_SW_ENABLE = 8;
    localparam int POS_FOCUS_CTRL = 9;
    localparam int POS_EXT_COUNT_LO = 16;
    localparam logic [7:0] EXT_COUNT = 8'h04;
    localparam int POS_SENT_ACCEPT = 2;
    localparam int POS_RECV_ACCEPT = 3;
    localparam int POS_SENT_ILLEGAL = 5;
    localparam int POS_RECV_ILLEGAL = 6;
    localparam int POS_ILLEGAL_REG = 7;
    localparam logic [7:0] RST_SPURIOUS_VEC = 8'hff;
    localparam logic [2:0] KIND_FIXED = 3'h0;
    localparam logic [2:0] KIND_LOWEST = 3'h1;
    localparam logic [2:0] KIND_SYS_MGMT = 3'h2;
    localparam logic [2:0] KIND_NON_MASKABLE = 3'h4;
    localparam logic [2:0] KIND_EXTERNAL = 3'h7;
endpackage : lvt_err_pkg

// >>> rtl/local_irq_lvt_error_spurious.sv
// Local vector entries, error status and spurious interrupt logic of a local controller.
// What this block does
// - Thermal event raises interrupt via thermal entry unless its mask bit 16 set.
// - Extended feature register bits 23:16 report four extended entries.
// - Four extended entries live at offsets 500h to 530h.
// - Each extended source uses the entry its own select input chooses.
// - Detected errors raise interrupt via error entry unless mask bit 16 set.
// - Writing error status copies accumulated errors to visible and clears accumulation.
// - Bit 2 records an outgoing message accepted by nobody.
// - Bit 3 records a received message accepted by nobody.
// - Bit 5 records an attempt to send an illegal vector.
// - Bit 6 records reception of an illegal vector.
// - Bit 7 records access to an unimplemented location in the page.
// - Task priority at or above acknowledged level delivers the spurious vector.
// - Spurious delivery leaves in-service untouched and expects no end of interrupt.
// - Spurious vector is bits 7:0 of the spurious register, read-write.
// - Bit 8 enables; while clear, system and pin kinds still accepted.
// - Disabled: pending state kept, fixed, lowest and external refused.
// - Disabled: all entry masks forced to one, clearing ignored.
// - Bit 9 set turns focus checking off; clear keeps it on.
// - Core is focus when a nonzero vector is in service or pending.
// - Mask one blocks an entry's interrupt; zero lets it through.
// - Entry kind field 10:8 chooses fixed, system, non-maskable or external.
// - Delivery pending bit 12 set while waiting, cleared when core takes it.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module local_irq_lvt_error_spurious (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [lvt_err_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic thermal_event,
    input wire logic perf_event,
    input wire logic [lvt_err_pkg::NUM_EXT-1:0] ext_src_event,
    input wire logic [2*lvt_err_pkg::NUM_EXT-1:0] ext_src_select,
    input wire logic sent_accept_error,
    input wire logic receive_accept_error,
    input wire logic sent_illegal_vector,
    input wire logic received_illegal_vector,
    output logic deliver_valid,
    output logic [7:0] deliver_number,
    output logic [2:0] deliver_kind,
    input wire logic core_taken,
    output logic request_set_pulse,
    output logic [7:0] request_set_number,
    input wire logic ack_req,
    input wire logic [7:0] ack_number,
    input wire logic [7:0] task_priority,
    output logic ack_done,
    output logic [7:0] ack_out_number,
    output logic ack_spurious,
    output logic in_service_set_pulse,
    input wire logic msg_in_valid,
    input wire logic [2:0] msg_in_kind,
    output logic msg_accepted,
    output logic msg_refused,
    input wire logic [7:0] focus_number,
    input wire logic in_service_hit,
    input wire logic request_pending_hit,
    output logic focus_core_hit,
    output logic software_enable_bit
);
    import lvt_err_pkg::*;

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic [NUM_ENTRIES-1:0][7:0] ent_num;
        logic [NUM_ENTRIES-1:0][2:0] ent_kind;
        logic [NUM_ENTRIES-1:0] ent_mask;
        logic [NUM_ENTRIES-1:0] ent_pend;
        logic [7:0] spur_num;
        logic sw_en;
        logic focus_ctrl;
        logic [7:0] err_vis;
        logic [7:0] err_acc;
        logic [31:0] rdata;
        logic dlv_valid;
        logic [2:0] dlv_idx;
        logic [7:0] dlv_num;
        logic [2:0] dlv_kind;
        logic req_set;
        logic [7:0] req_num;
        logic ack_done;
        logic [7:0] ack_num;
        logic ack_spur;
        logic isr_set;
        logic msg_ok;
        logic msg_no;
        logic focus_hit;
    } state_s;

    state_s state_q;
    state_s state_d;

    // ************************************************************
    // Per-entry event sources.
    // ************************************************************
    logic [NUM_ENTRIES-1:0] ent_event;
    logic [7:0] err_new;

    // Error entry fires on freshly set error flags.
    // new flag trigger
    assign ent_event[IDX_ERROR] = |(err_new & ~state_q.err_acc);
    assign ent_event[IDX_THERMAL] = thermal_event & THERMAL_PRESENT;
    assign ent_event[IDX_PERF] = perf_event;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
            logic [NUM_EXT-1:0] hit;
            genvar gj;
            for (gj = 0; gj < NUM_EXT; gj++) begin : g_src
                assign hit[gj] = ext_src_event[gj] & (ext_src_select[2*gj +: 2] == 2'(gi));
            end
            assign ent_event[IDX_EXT0+gi] = |hit;
        end
    endgenerate

    // ************************************************************
    // Address decode.
    // ************************************************************
    logic acc;
    logic hit_spur;
    logic hit_err;
    logic hit_feat;
    logic [NUM_ENTRIES-1:0] hit_ent;
    logic mapped;

    always_comb begin
        acc = reg_wr | reg_rd;
        hit_spur = (reg_addr == OFS_SPURIOUS);
        hit_err = (reg_addr == OFS_ERROR_FLAGS);
        hit_feat = (reg_addr == OFS_EXT_FEATURE);
        hit_ent = '0;
        hit_ent[IDX_THERMAL] = (reg_addr == OFS_THERMAL) & THERMAL_PRESENT;
        hit_ent[IDX_PERF] = (reg_addr == OFS_PERF);
        hit_ent[IDX_ERROR] = (reg_addr == OFS_ERROR_ENTRY);
        for (int k = 0; k < NUM_EXT; k++) begin
            hit_ent[IDX_EXT0+k] = (reg_addr == OFS_EXT_FIRST + 12'(16 * k));
        end
        mapped = hit_spur | hit_err | hit_feat | (|hit_ent);
    end

    // ************************************************************
    // Error sources.
    // ************************************************************
    // Kept apart from the next-state logic so the error entry event forms no loop.
    always_comb begin
        // Error sources, collected into the accumulator.
        err_new = '0;
        err_new[POS_SENT_ACCEPT] = sent_accept_error;
        err_new[POS_RECV_ACCEPT] = receive_accept_error;
        err_new[POS_SENT_ILLEGAL] = sent_illegal_vector;
        err_new[POS_RECV_ILLEGAL] = received_illegal_vector;
        err_new[POS_ILLEGAL_REG] = acc & ~mapped;
    end

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        logic [31:0] rd;
        logic found;
        state_d = state_q;
        rd = '0;
        found = 1'b0;
        state_d.req_set = 1'b0;
        state_d.ack_done = 1'b0;
        state_d.ack_spur = 1'b0;
        state_d.isr_set = 1'b0;
        state_d.msg_ok = 1'b0;
        state_d.msg_no = 1'b0;
        state_d.rdata = '0;

        if (reg_wr && hit_err) begin
            state_d.err_vis = state_q.err_acc;
            state_d.err_acc = err_new;
        end else begin
            state_d.err_acc = state_q.err_acc | err_new;
        end

        // Register writes.
        if (reg_wr) begin
            if (hit_spur) begin
                state_d.spur_num = reg_wdata[7:0];
                state_d.sw_en = reg_wdata[POS_SW_ENABLE];
                state_d.focus_ctrl = reg_wdata[POS_FOCUS_CTRL];
            end
            for (int k = 0; k < NUM_ENTRIES; k++) begin
                if (hit_ent[k]) begin
                    state_d.ent_num[k] = reg_wdata[7:0];
                    state_d.ent_kind[k] = reg_wdata[POS_KIND_LO +: 3];
                    state_d.ent_mask[k] = reg_wdata[POS_MASK];
                end
            end
        end
        if (!state_d.sw_en) begin
            state_d.ent_mask = '1;
        end

        // Register reads, answered one cycle later.
        if (reg_rd) begin
            if (hit_spur) begin
                rd[7:0] = state_q.spur_num;
                rd[POS_SW_ENABLE] = state_q.sw_en;
                rd[POS_FOCUS_CTRL] = state_q.focus_ctrl;
            end
            if (hit_err) begin
                rd[7:0] = state_q.err_vis;
            end
            if (hit_feat) begin
                rd[POS_EXT_COUNT_LO +: 8] = EXT_COUNT;
            end
            for (int k = 0; k < NUM_ENTRIES; k++) begin
                if (hit_ent[k]) begin
                    rd[7:0] = state_q.ent_num[k];
                    rd[POS_KIND_LO +: 3] = state_q.ent_kind[k];
                    rd[POS_PENDING] = state_q.ent_pend[k];
                    rd[POS_MASK] = state_q.ent_mask[k];
                end
            end
            state_d.rdata = rd;
        end

        // Core takes the presented entry.
        if (state_q.dlv_valid && core_taken) begin
            state_d.ent_pend[state_q.dlv_idx] = 1'b0;
            state_d.req_set = 1'b1;
            state_d.req_num = state_q.ent_num[state_q.dlv_idx];
        end

        // New events raise pending unless masked.
        for (int k = 0; k < NUM_ENTRIES; k++) begin
            if (ent_event[k] && !state_q.ent_mask[k]) begin
                state_d.ent_pend[k] = 1'b1;
            end
        end

        // Present the lowest pending entry to the core.
        state_d.dlv_valid = 1'b0;
        for (int k = 0; k < NUM_ENTRIES; k++) begin
            if (state_d.ent_pend[k] && !found) begin
                found = 1'b1;
                state_d.dlv_valid = 1'b1;
                state_d.dlv_idx = 3'(k);
            end
        end

        // Number and kind of the presented entry are registered here,
        // so both outputs come straight from flops.
        state_d.dlv_num = state_d.ent_num[state_d.dlv_idx];
        state_d.dlv_kind = state_d.ent_kind[state_d.dlv_idx];

        // Acknowledge path with spurious substitution.
        if (ack_req) begin
            state_d.ack_done = 1'b1;
            if (task_priority[7:4] >= ack_number[7:4]) begin
                state_d.ack_num = state_q.spur_num;
                state_d.ack_spur = 1'b1;
            end else begin
                state_d.ack_num = ack_number;
                state_d.isr_set = 1'b1;
            end
        end

        // Incoming message acceptance.
        if (msg_in_valid) begin
            if (!state_q.sw_en && (msg_in_kind == KIND_FIXED || msg_in_kind == KIND_LOWEST
                    || msg_in_kind == KIND_EXTERNAL)) begin
                state_d.msg_no = 1'b1;
            end else begin
                state_d.msg_ok = 1'b1;
            end
        end

        state_d.focus_hit = ~state_q.focus_ctrl & (in_service_hit | request_pending_hit)
            & (focus_number != 8'h00);
    end

    // ************************************************************
    // Registers.
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= '0;
            state_q.ent_mask <= '1;
            state_q.spur_num <= RST_SPURIOUS_VEC;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign reg_rdata = state_q.rdata;
    assign deliver_valid = state_q.dlv_valid;
    assign deliver_number = state_q.dlv_num;
    assign deliver_kind = state_q.dlv_kind;
    assign request_set_pulse = state_q.req_set;
    assign request_set_number = state_q.req_num;
    assign ack_done = state_q.ack_done;
    assign ack_out_number = state_q.ack_num;
    assign ack_spurious = state_q.ack_spur;
    assign in_service_set_pulse = state_q.isr_set;
    assign msg_accepted = state_q.msg_ok;
    assign msg_refused = state_q.msg_no;
    assign focus_core_hit = state_q.focus_hit;
    assign software_enable_bit = state_q.sw_en;
endmodule : local_irq_lvt_error_spurious
`default_nettype wire

// >>> tb/core_side_model.sv
// Core-side model that takes presented interrupts after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic deliver_valid,
    input wire logic [3:0] take_delay,
    output logic core_taken
);
    int wait_q;
    always @(posedge core_clk) begin
        if (srst || !deliver_valid || core_taken) begin
            wait_q <= 0;
            core_taken <= 1'b0;
        end else if (wait_q >= take_delay) begin
            core_taken <= 1'b1;
        end else begin
            wait_q <= wait_q + 1;
        end
    end
endmodule : core_side_model
`default_nettype wire

// >>> tb/local_irq_lvt_error_spurious_tb.sv
// Testbench for the local vector entry, error status and spurious block.
`timescale 1ns/1ps
`default_nettype none
module local_irq_lvt_error_spurious_tb;
    import lvt_err_pkg::*;
    logic core_clk, srst, reg_wr, reg_rd, thermal_event, perf_event, core_taken, ack_req;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [3:0] ext_src_event, take_delay;
    logic [7:0] ext_src_select, ack_number, task_priority, focus_number, spur, an, tp;
    logic sent_accept_error, receive_accept_error, sent_illegal_vector, received_illegal_vector;
    logic deliver_valid, request_set_pulse, ack_done, ack_spurious, in_service_set_pulse;
    logic msg_in_valid, msg_accepted, msg_refused, in_service_hit, request_pending_hit;
    logic focus_core_hit, software_enable_bit, sp, fe;
    logic [7:0] deliver_number, request_set_number, ack_out_number;
    logic [2:0] deliver_kind, msg_in_kind;
    logic [11:0] ofs [7] = '{OFS_THERMAL, OFS_PERF, OFS_ERROR_ENTRY, OFS_EXT_FIRST, 12'h510,
        12'h520, OFS_EXT_LAST};
    logic [2:0] kinds [4] = '{3'h0, 3'h2, 3'h4, 3'h7};
    int num_errors, total_checks, cycles, exp_err, sel;
    local_irq_lvt_error_spurious u_local_irq_lvt_error_spurious (.*);
    core_side_model u_core_side_model (.core_clk(core_clk), .srst(srst),
        .deliver_valid(deliver_valid), .take_delay(take_delay), .core_taken(core_taken));
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            print_verdict();
        end
    end
    // ****************************************
    // Tasks.
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, v, "register read");
    endtask : rd_chk
    task automatic pulse_src(input int k);
        @(posedge core_clk);
        take_delay <= 4'($urandom % 8);
        case (k)
            0: thermal_event <= 1'b1;
            1: perf_event <= 1'b1;
            2: sent_accept_error <= 1'b1;
            3: receive_accept_error <= 1'b1;
            4: sent_illegal_vector <= 1'b1;
            5: received_illegal_vector <= 1'b1;
            default: ext_src_event[k-6] <= 1'b1;
        endcase
        @(posedge core_clk);
        {thermal_event, perf_event, ext_src_event} <= 6'h0;
        {sent_accept_error, receive_accept_error, sent_illegal_vector} <= 3'h0;
        received_illegal_vector <= 1'b0;
    endtask : pulse_src
    task automatic wait_req(input logic [7:0] exp);
        logic [10:0] seen;
        seen = 11'h0;
        for (int n = 0; n < 40 && request_set_pulse !== 1'b1; n++) begin
            if (deliver_valid === 1'b1) seen = {deliver_kind, deliver_number};
            @(posedge core_clk) #1;
        end
        check({21'h0, seen}, {21'h0, kinds[exp[1:0]], exp}, "presented entry");
        check({23'h0, request_set_pulse, request_set_number}, {23'h0, 1'b1, exp}, "request");
    endtask : wait_req
    task automatic msg_all(input logic en);
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk);
            msg_in_valid <= 1'b1; msg_in_kind <= 3'(k);
            @(posedge core_clk);
            msg_in_valid <= 1'b0;
            fe = !en && (k == 0 || k == 1 || k == 7);
            #1 check({msg_refused, msg_accepted}, {fe, !fe}, "message answer");
        end
    endtask : msg_all
    task automatic focus_loop(input logic fcc);
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk);
            {in_service_hit, request_pending_hit} <= 2'($urandom); focus_number <= 8'($urandom % 3);
            @(posedge core_clk);
            fe = !fcc && (in_service_hit || request_pending_hit) && focus_number != 8'h0;
            #1 check(focus_core_hit, fe, "focus");
        end
    endtask : focus_loop
    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        {core_clk, reg_wr, reg_rd, thermal_event, perf_event, ack_req, msg_in_valid} = 7'h0;
        {sent_accept_error, receive_accept_error, sent_illegal_vector} = 3'h0;
        {received_illegal_vector, in_service_hit, request_pending_hit} = 3'h0;
        {reg_addr, reg_wdata, ext_src_event, take_delay, ext_src_select} = 0;
        {ack_number, task_priority, focus_number, msg_in_kind} = 0;
        srst = 1'b1;
        void'($urandom(32'he0d744b8));
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        rd_chk(OFS_SPURIOUS, 32'h000000ff);
        foreach (ofs[i]) rd_chk(ofs[i], 32'h00010000);
        rd_chk(OFS_EXT_FEATURE, 32'h00040000);
        wr(OFS_THERMAL, 32'h00000031);
        rd_chk(OFS_THERMAL, 32'h00010031);
        msg_all(1'b0);
        rd_chk(12'h0f4, 32'h0);
        wr(OFS_ERROR_FLAGS, 32'h0);
        rd_chk(OFS_ERROR_FLAGS, 32'h80);
        $display("test disabled done");
        spur = 8'($urandom);
        wr(OFS_SPURIOUS, {24'h1, spur});
        rd_chk(OFS_SPURIOUS, {24'h1, spur});
        check(software_enable_bit, 1'b1, "enable");
        msg_all(1'b1);
        foreach (ofs[i]) wr(ofs[i], {21'h0, kinds[i % 4], 8'h40 + 8'(i)});
        foreach (ofs[i]) rd_chk(ofs[i], {21'h0, kinds[i % 4], 8'h40 + 8'(i)});
        pulse_src(0);
        wait_req(8'h40);
        pulse_src(1);
        wait_req(8'h41);
        wr(OFS_THERMAL, 32'h00010040);
        pulse_src(0);
        repeat (6) @(posedge core_clk);
        #1 check(deliver_valid, 1'b0, "masked event");
        for (int j = 0; j < 4; j++) begin
            sel = $urandom % 4;
            @(posedge core_clk);
            ext_src_select[2*j +: 2] <= 2'(sel);
            pulse_src(6 + j);
            wait_req(8'h43 + 8'(sel));
        end
        $display("test delivery done");
        exp_err = 0;
        for (int k = 2; k < 6; k++) begin
            pulse_src(k);
            wait_req(8'h42);
            exp_err |= 1 << (k < 4 ? k : k + 1);
        end
        wr(OFS_ERROR_FLAGS, 32'h0);
        rd_chk(OFS_ERROR_FLAGS, 32'(exp_err));
        $display("test errors done");
        for (int k = 0; k < 8; k++) begin
            an = 8'($urandom);
            tp = 8'($urandom);
            @(posedge core_clk);
            ack_req <= 1'b1; ack_number <= an; task_priority <= tp;
            @(posedge core_clk);
            ack_req <= 1'b0;
            sp = tp[7:4] >= an[7:4];
            #1 check({21'h0, ack_done, ack_spurious, in_service_set_pulse, ack_out_number},
                {21'h0, 1'b1, sp, !sp, sp ? spur : an}, "ack");
        end
        focus_loop(1'b0);
        wr(OFS_SPURIOUS, {24'h3, spur});
        focus_loop(1'b1);
        $display("test ack and focus done");
        print_verdict();
    end
endmodule : local_irq_lvt_error_spurious_tb
`default_nettype wire

// >>> tb/lvt_err_chk.sv
// Concurrent checks on the ports of the local vector entry block.
`timescale 1ns/1ps
`default_nettype none
module lvt_err_chk import lvt_err_pkg::*; (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [lvt_err_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic deliver_valid,
    input wire logic core_taken,
    input wire logic request_set_pulse,
    input wire logic ack_req,
    input wire logic [7:0] ack_number,
    input wire logic [7:0] task_priority,
    input wire logic ack_done,
    input wire logic ack_spurious,
    input wire logic in_service_set_pulse,
    input wire logic msg_in_valid,
    input wire logic [2:0] msg_in_kind,
    input wire logic msg_accepted,
    input wire logic msg_refused,
    input wire logic in_service_hit,
    input wire logic request_pending_hit,
    input wire logic focus_core_hit,
    input wire logic software_enable_bit
);
    // ****************************************
    // Assertions.
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_refusable;
        msg_in_valid && !software_enable_bit && (msg_in_kind inside {3'h0, 3'h1, 3'h7});
    endsequence
    sequence s_spur_ack;
        ack_req && (task_priority[7:4] >= ack_number[7:4]);
    endsequence
    chk_ack_answer: assert property (ack_req |=> ack_done)
        else $error("ack not answered");
    chk_spur_given: assert property (s_spur_ack |=> ack_spurious)
        else $error("spurious not given");
    chk_spur_no_isr: assert property (ack_done && ack_spurious |-> !in_service_set_pulse)
        else $error("spurious set in service");
    chk_real_ack: assert property (ack_req && (task_priority[7:4] < ack_number[7:4])
        |=> in_service_set_pulse && !ack_spurious) else $error("real ack wrong");
    chk_msg_refused: assert property (s_refusable |=> msg_refused && !msg_accepted)
        else $error("message not refused");
    chk_msg_system: assert property (msg_in_valid && (msg_in_kind inside {3'h2, 3'h4})
        |=> msg_accepted) else $error("system message refused");
    chk_focus_idle: assert property (!in_service_hit && !request_pending_hit
        |=> !focus_core_hit) else $error("focus without hit");
    chk_unmapped_zero: assert property (reg_rd && reg_addr[3:0] != 4'h0
        |=> reg_rdata == 32'h0) else $error("unmapped read nonzero");
    chk_take_request: assert property (deliver_valid && core_taken
        |=> request_set_pulse) else $error("request flag not set");
endmodule : lvt_err_chk
bind local_irq_lvt_error_spurious lvt_err_chk u_lvt_err_chk (.*);
`default_nettype wire
